//--- hw/tcc_loop_filter.sv
// loop filter: decides whether a change-of-flow word is stored and reloads comparator c
`timescale 1ns/100ps
module tcc_loop_filter #(
  parameter int ADDR_W = tcc_pkg::TCC_ADDR_W
) (
  // mode inputs
  input wire logic loop_mode,
  input wire logic event_only,
  // candidate word
  input wire logic capture_req,
  input wire logic [ADDR_W-1:0] cof_addr,
  input wire logic [ADDR_W-1:0] cmp_c,
  // decision
  output logic store,
  output logic load_cmp_c
);
  import tcc_pkg::*;

  // comparing only in loop mode outside event-only modes
  always_comb begin
    if (loop_mode && !event_only) begin
      store = capture_req && (cof_addr != cmp_c);
      load_cmp_c = capture_req && (cof_addr != cmp_c);
    end else begin
      store = capture_req;
      load_cmp_c = 1'b0;
    end
  end
endmodule

//--- hw/tcc_pkg.sv
// package: register map, field positions, reset values and widths for trace capture control
package tcc_pkg;
  // register byte addresses (word aligned on apb)
  localparam logic [3:0] TCC_IDX_EXT = 4'hB;
  localparam logic [3:0] TCC_IDX_CTRL = 4'hC;
  localparam logic [7:0] TCC_ADDR_EXT = {2'b00, TCC_IDX_EXT, 2'b00}; // index times four
  localparam logic [7:0] TCC_ADDR_CTRL = {2'b00, TCC_IDX_CTRL, 2'b00}; // index times four
  localparam logic [7:0] TCC_ADDR_CMPC = 8'h34; // comparator c loop address
  localparam logic [7:0] TCC_ADDR_CNT = 8'h38; // fifo valid count
  localparam logic [7:0] TCC_ADDR_STAT = 8'h3C; // armed flag
  localparam logic [7:0] TCC_ADDR_TRIG = 8'h40; // begin bit and trigger mode
  // control field positions
  localparam int TCC_CTRL_EN = 7;
  localparam int TCC_CTRL_ARM = 6;
  localparam int TCC_CTRL_TAG = 5;
  localparam int TCC_CTRL_BRK = 4;
  localparam int TCC_CTRL_LOOP = 0;
  // extension field positions
  localparam int TCC_EXT_PAGED = 7;
  localparam int TCC_EXT_B16 = 0;
  // trigger register fields
  localparam int TCC_TRIG_BEGIN = 6;
  // reset values
  localparam logic [7:0] TCC_CTRL_RST = 8'hC0;
  localparam logic [7:0] TCC_EXT_RST = 8'h00;
  localparam logic [7:0] TCC_TRIG_RST = 8'h40;
  localparam logic [7:0] TCC_CTRL_WMASK = 8'hF1;
  // writable trigger bits: select, begin and mode
  localparam logic [7:0] TCC_TRIG_WMASK = 8'hCF;
  // extension bits that read back, the rest read zero
  localparam logic [7:0] TCC_EXT_RMASK = 8'h81;
  // event-only trigger modes
  localparam logic [3:0] TCC_MODE_EVB = 4'h3;
  localparam logic [3:0] TCC_MODE_AEVB = 4'h4;
  // fifo count limit
  localparam logic [3:0] TCC_CNT_MAX = 4'h8;
  localparam int TCC_ADDR_W = 17;
endpackage

//--- hw/tcc_reset_ctl.sv
// reset qualifier: tells apart full reset and end-of-trace reset that keeps state
`timescale 1ns/100ps
module tcc_reset_ctl (
  // resets, sampled by the registers that use them
  input wire logic srst,
  input wire logic end_trace_reset,
  // current state
  input wire logic enabled,
  input wire logic begin_bit,
  // qualified resets
  output logic full_reset,
  output logic keep_reset
);
  import tcc_pkg::*;

  // a kept reset only when enabled and begin clear, otherwise it is a full reset
  always_comb begin
    keep_reset = end_trace_reset && !srst && enabled && !begin_bit;
    full_reset = srst || (end_trace_reset && !keep_reset);
  end
endmodule

//--- hw/tcc_top.sv
// top: trace capture control registers, loop capture and break request logic
//
// Contract
// - Each captured word stores its paged-access flag in bit 7 of the extension register.
// - Bit 0 of the extension register returns address bit 16 of the current word.
// - The extension register clears on full reset and keeps its bits on a kept end reset.
// - Enable bit 7 turns the module on and is forced to zero while secured.
// - Arm bit 6 allows comparing and storing only while it is one.
// - Bit 5 picks tag (one) or force (zero) breaks, and only matters with breaks enabled.
// - Break enable bit 4 lets the end of a run and a comparator c match request a break.
// - With loop mode off every qualifying change-of-flow word is stored.
// - In loop mode a word equal to comparator c is not stored and the count stays.
// - In loop mode a differing word is stored with its flag and loaded into comparator c.
// - Loop mode has no effect in event-only trigger modes.
// - Control resets to 0xC0, and a kept end reset clears only arm and break enable.
// - The valid count clears on arming, counts stored words, stops at eight, never falls.
// - While enabled the armed flag reads as a copy of the arm bit.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module tcc_top #(
  parameter int ADDR_W = tcc_pkg::TCC_ADDR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic end_trace_reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic secured,
  input wire logic cof_valid,
  input wire logic [ADDR_W-1:0] cof_addr,
  input wire logic paged_access_flag,
  input wire logic cmp_c_match,
  input wire logic run_end,
  // outputs to core and fifo
  output logic store_word,
  output logic [ADDR_W-1:0] store_addr,
  output logic store_paged,
  output logic break_req,
  output logic break_is_tag,
  output logic armed_status_flag
);
  import tcc_pkg::*;

  // ************************************************
  // elaboration checks
  // ************************************************
  // extension bit 16 and the paged flag only make sense for a 17-bit core address
  if (ADDR_W != TCC_ADDR_W) begin : g_bad_addr_w
    $error("tcc_top needs a 17-bit core address");
  end
  // comparator c is read back in one bus word, so it cannot be wider than the bus
  if (ADDR_W > 32) begin : g_addr_too_wide
    $error("tcc_top core address is wider than the read word");
  end

  // ************************************************
  // state
  // ************************************************
  logic [7:0] trace_control;
  logic [7:0] trace_word_extension;
  logic [7:0] trigger_setup;
  logic [ADDR_W-1:0] cmp_c;
  logic [3:0] fifo_valid_count;
  logic full_reset;
  logic keep_reset;
  logic module_enable_bit;
  logic arm_bit;
  logic break_request_enable;
  logic loop_capture_mode;
  logic event_only;
  logic capture_req;
  logic load_cmp_c;
  logic wr_en;
  logic rd_setup;
  logic addr_hit;
  // per-register write strobes from the shared decode
  logic wr_ctrl;
  logic wr_trig;
  logic wr_cmpc;
  logic arm_write;
  // read word picked in the setup phase
  logic [31:0] next_prdata;

  assign module_enable_bit = trace_control[TCC_CTRL_EN];
  assign arm_bit = trace_control[TCC_CTRL_ARM];
  assign break_request_enable = trace_control[TCC_CTRL_BRK];
  assign loop_capture_mode = trace_control[TCC_CTRL_LOOP];

  // ************************************************
  // reset qualification
  // ************************************************
  tcc_reset_ctl u_rst (
    .srst(srst),
    .end_trace_reset(end_trace_reset),
    .enabled(module_enable_bit),
    .begin_bit(trigger_setup[TCC_TRIG_BEGIN]),
    .full_reset(full_reset),
    .keep_reset(keep_reset)
  );

  // ************************************************
  // apb decode
  // ************************************************
  // one decode for every register strobe, so the write paths cannot drift apart
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
      input logic [7:0] target);
    return strobe && (addr == target);
  endfunction

  // zero wait states: the read word is loaded in setup and stands in the access phase
  // unmapped addresses answer with an error
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_ctrl = reg_hit(wr_en, paddr, TCC_ADDR_CTRL);
  assign wr_trig = reg_hit(wr_en, paddr, TCC_ADDR_TRIG);
  assign wr_cmpc = reg_hit(wr_en, paddr, TCC_ADDR_CMPC);
  always_comb begin
    unique case (paddr)
      TCC_ADDR_EXT, TCC_ADDR_CTRL, TCC_ADDR_CMPC, TCC_ADDR_CNT, TCC_ADDR_STAT,
      TCC_ADDR_TRIG: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_hit;

  // ************************************************
  // control register
  // ************************************************
  // secure forces enable low each cycle so a set write can never stick
  always_ff @(posedge clk_sys) begin
    if (full_reset) begin
      trace_control <= TCC_CTRL_RST;
    end else if (keep_reset) begin
      trace_control[TCC_CTRL_ARM] <= 1'b0;
      trace_control[TCC_CTRL_BRK] <= 1'b0;
    end else if (wr_ctrl) begin
      trace_control <= pwdata[7:0] & TCC_CTRL_WMASK;
    end
    // last assignment wins, so secure beats reset values and writes alike
    if (secured) begin
      trace_control[TCC_CTRL_EN] <= 1'b0;
    end
  end

  // trigger setup: only writable while disarmed, keeps on a kept reset
  always_ff @(posedge clk_sys) begin
    if (full_reset) begin
      trigger_setup <= TCC_TRIG_RST;
    end else if (!keep_reset && wr_trig && !arm_bit) begin
      trigger_setup <= pwdata[7:0] & TCC_TRIG_WMASK;
    end
  end

  assign event_only = (trigger_setup[3:0] == TCC_MODE_EVB) ||
                      (trigger_setup[3:0] == TCC_MODE_AEVB);

  // ************************************************
  // capture path
  // ************************************************
  // nothing is compared or stored unless enabled and armed
  assign capture_req = cof_valid && module_enable_bit && arm_bit;

  tcc_loop_filter #(
    .ADDR_W(ADDR_W)
  ) u_loop (
    .loop_mode(loop_capture_mode),
    .event_only(event_only),
    .capture_req(capture_req),
    .cof_addr(cof_addr),
    .cmp_c(cmp_c),
    .store(store_word),
    .load_cmp_c(load_cmp_c)
  );

  assign store_addr = cof_addr;
  assign store_paged = paged_access_flag;

  // comparator c: software load, or reload by loop capture
  always_ff @(posedge clk_sys) begin
    if (full_reset) begin
      cmp_c <= '0;
    end else if (load_cmp_c) begin
      cmp_c <= cof_addr;
    end else if (wr_cmpc) begin
      // a loop reload in the same cycle wins over software
      cmp_c <= pwdata[ADDR_W-1:0];
    end
  end

  // extension word follows each stored word
  always_ff @(posedge clk_sys) begin
    if (full_reset) begin
      trace_word_extension <= TCC_EXT_RST;
    end else if (!keep_reset && store_word) begin
      trace_word_extension[TCC_EXT_PAGED] <= paged_access_flag;
      trace_word_extension[TCC_EXT_B16] <= cof_addr[ADDR_W-1];
    end
  end

  // ************************************************
  // valid count
  // ************************************************
  // any control write with the arm bit set restarts the count, even when already armed
  assign arm_write = wr_ctrl && pwdata[TCC_CTRL_ARM];
  always_ff @(posedge clk_sys) begin
    if (full_reset) begin
      fifo_valid_count <= 4'h0;
    end else if (arm_write) begin
      fifo_valid_count <= 4'h0;
    end else if (store_word && fifo_valid_count != TCC_CNT_MAX) begin
      fifo_valid_count <= fifo_valid_count + 4'h1;
    end
  end

  // ************************************************
  // break requests and status
  // ************************************************
  // tag selection reaches the core whenever break enable is set, with or without a request
  always_ff @(posedge clk_sys) begin
    if (full_reset || keep_reset) begin
      break_req <= 1'b0;
      break_is_tag <= 1'b0;
    end else begin
      break_req <= break_request_enable && module_enable_bit &&
                   (run_end || cmp_c_match);
      break_is_tag <= break_request_enable && trace_control[TCC_CTRL_TAG];
    end
  end

  assign armed_status_flag = module_enable_bit && arm_bit;

  // ************************************************
  // read data
  // ************************************************
  // read word chosen from the address already valid in the setup phase
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      TCC_ADDR_EXT: next_prdata = {24'h0, trace_word_extension & TCC_EXT_RMASK};
      TCC_ADDR_CTRL: next_prdata = {24'h0, trace_control};
      TCC_ADDR_CMPC: next_prdata = 32'(cmp_c);
      TCC_ADDR_CNT: next_prdata = {28'h0, fifo_valid_count};
      TCC_ADDR_STAT: next_prdata = {31'h0, armed_status_flag};
      TCC_ADDR_TRIG: next_prdata = {24'h0, trigger_setup};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // registered in setup so the word already stands at the pready edge;
  // a value that hardware changes during that one setup cycle shows on the next read
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end
endmodule

//--- verification/tcc_core_model.sv
// core model: change-of-flow candidates, comparator c hits and run ends
`timescale 1ns/100ps
module tcc_core_model (
  // clock
  input wire logic clk_sys,
  // core events
  output logic cof_valid,
  output logic [16:0] cof_addr,
  output logic paged_access_flag,
  output logic cmp_c_match,
  output logic run_end
);
  // ********************
  // event drivers
  // ********************
  initial begin
    cof_valid = 1'b0;
    cof_addr = 17'h0;
    paged_access_flag = 1'b0;
    cmp_c_match = 1'b0;
    run_end = 1'b0;
  end
  // released lines show the inverse so stale values never pass
  task automatic change_of_flow(input logic [16:0] a, input logic pg);
    @(posedge clk_sys);
    cof_valid <= 1'b1;
    cof_addr <= a;
    paged_access_flag <= pg;
    @(posedge clk_sys);
    cof_valid <= 1'b0;
    cof_addr <= ~a;
    paged_access_flag <= ~pg;
  endtask
  // one-cycle pulse of run end or comparator c hit
  task automatic hit(input logic is_end);
    @(posedge clk_sys);
    run_end <= is_end;
    cmp_c_match <= !is_end;
    @(posedge clk_sys);
    run_end <= 1'b0;
    cmp_c_match <= 1'b0;
  endtask
endmodule

//--- verification/tcc_props.sv
// checker: port-level properties of the trace capture control block
`timescale 1ns/100ps
module tcc_props import tcc_pkg::*; #(
  parameter int ADDR_W = TCC_ADDR_W
) (
  // clock, reset and bus
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // core side
  input wire logic secured,
  input wire logic cof_valid,
  input wire logic [ADDR_W-1:0] cof_addr,
  input wire logic paged_access_flag,
  input wire logic cmp_c_match,
  input wire logic run_end,
  input wire logic store_word,
  input wire logic [ADDR_W-1:0] store_addr,
  input wire logic store_paged,
  input wire logic break_req,
  input wire logic armed_status_flag
);
  logic acc;
  logic mapped;
  // ********************
  // bus decode seen from outside
  // ********************
  assign acc = psel && penable;
  assign mapped = paddr inside {TCC_ADDR_EXT, TCC_ADDR_CTRL, TCC_ADDR_CMPC, TCC_ADDR_CNT,
    TCC_ADDR_STAT, TCC_ADDR_TRIG};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // holes answer with an error, real registers never do
  bad_addr_a: assert property (acc && !mapped |-> pslverr) else $error("hole not refused");
  good_addr_a: assert property (acc && mapped |-> !pslverr) else $error("register refused");
  store_gate_a: assert property (store_word |-> cof_valid && armed_status_flag)
    else $error("store while not armed");
  store_copy_a: assert property (store_word |-> store_addr == cof_addr &&
    store_paged == paged_access_flag) else $error("stored word differs");
  break_cause_a: assert property (break_req |-> $past(run_end) || $past(cmp_c_match))
    else $error("break without cause");
  // enable is registered, so the clear shows one edge later
  secure_off_a: assert property (secured [*2] |-> !armed_status_flag)
    else $error("enabled while secured");
  reset_val_a: assert property ($fell(srst) && !$past(secured) |-> armed_status_flag)
    else $error("control not armed after reset");
  // the read word is loaded only by a read setup phase
  rd_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved");
  store_c: cover property (store_word);
  break_c: cover property (break_req);
  hole_c: cover property (acc && pslverr);
endmodule
bind tcc_top tcc_props #(.ADDR_W(ADDR_W)) i_props (.clk_sys, .srst, .psel, .penable, .pwrite,
  .paddr, .prdata, .pslverr, .secured, .cof_valid, .cof_addr, .paged_access_flag, .cmp_c_match,
  .run_end, .store_word, .store_addr, .store_paged, .break_req, .armed_status_flag);

//--- verification/tcc_top_tb.sv
// testbench: registers, capture, loop, break and reset scenarios
`timescale 1ns/100ps
module tcc_top_tb;
  import tcc_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic end_trace_reset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic secured = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, err, n_store, last_st;
  logic pready, pslverr, store_word, store_paged, break_req, break_is_tag, armed_status_flag;
  logic cof_valid, paged_access_flag, cmp_c_match, run_end;
  logic [16:0] cof_addr, store_addr;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  // ********************
  // clock, counters and helpers
  // ********************
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      conclude();
    end
  end
  // store strobes are combinational, so they are counted mid-cycle where they have settled
  always @(negedge clk_sys) begin
    if (store_word === 1'b1) begin
      n_store++;
      last_st = {14'h0, store_paged, store_addr};
    end
  end
  tcc_top i_dut (.clk_sys, .srst, .end_trace_reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .secured, .cof_valid, .cof_addr, .paged_access_flag,
    .cmp_c_match, .run_end, .store_word, .store_addr, .store_paged, .break_req,
    .break_is_tag, .armed_status_flag);
  tcc_core_model i_core (.clk_sys, .cof_valid, .cof_addr, .paged_access_flag, .cmp_c_match,
    .run_end);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // read data stands in the access phase and is taken at the pready edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    err = {31'h0, pslverr};
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic t_reset;
    rdc(TCC_ADDR_CTRL, 32'hC0);
    apb(TCC_ADDR_EXT, 1'b1, 32'hFF);
    rdc(TCC_ADDR_EXT, 32'h0);
    apb(8'h04, 1'b0, 32'h0);
    chk(err, 32'h1);
  endtask
  task automatic t_capture;
    apb(TCC_ADDR_CTRL, 1'b1, 32'h80);
    n_store = 32'h0;
    i_core.change_of_flow(17'h1_2345, 1'b1);
    chk(n_store, 32'h0);
    chk({31'h0, armed_status_flag}, 32'h0);
    apb(TCC_ADDR_CTRL, 1'b1, 32'hC0);
    i_core.change_of_flow(17'h1_2345, 1'b1);
    chk(last_st, 32'h3_2345);
    rdc(TCC_ADDR_EXT, 32'h81);
    i_core.change_of_flow(17'h0_2345, 1'b0);
    rdc(TCC_ADDR_EXT, 32'h0);
    for (int i = 0; i < 8; i++) i_core.change_of_flow(17'h0_0100, 1'b0);
    chk(n_store, 32'hA);
    rdc(TCC_ADDR_CNT, 32'h8);
  endtask
  task automatic t_loop;
    apb(TCC_ADDR_CTRL, 1'b1, 32'hC1);
    n_store = 32'h0;
    i_core.change_of_flow(17'h0_1111, 1'b0);
    i_core.change_of_flow(17'h0_1111, 1'b0);
    i_core.change_of_flow(17'h1_4444, 1'b1);
    chk(last_st, 32'h3_4444);
    rdc(TCC_ADDR_CNT, 32'h2);
    rdc(TCC_ADDR_CMPC, 32'h1_4444);
    for (int m = 3; m < 5; m++) begin
      apb(TCC_ADDR_CTRL, 1'b1, 32'h81);
      apb(TCC_ADDR_TRIG, 1'b1, m);
      apb(TCC_ADDR_CTRL, 1'b1, 32'hC1);
      i_core.change_of_flow(17'h1_4444, 1'b1);
      i_core.change_of_flow(17'h1_4444, 1'b1);
      rdc(TCC_ADDR_CNT, 32'h2);
    end
  endtask
  // break follows its cause by one edge
  task automatic t_break;
    for (int t = 0; t < 2; t++) begin
      apb(TCC_ADDR_CTRL, 1'b1, 32'hD0 ^ (t << 5));
      i_core.hit(t[0]);
      @(negedge clk_sys);
      chk({30'h0, break_req, break_is_tag}, {30'h0, 1'b1, t[0]});
    end
    apb(TCC_ADDR_CTRL, 1'b1, 32'hE0);
    i_core.hit(1'b1);
    @(negedge clk_sys);
    chk({30'h0, break_req, break_is_tag}, 32'h0);
  endtask
  task automatic t_ends;
    apb(TCC_ADDR_CTRL, 1'b1, 32'h81);
    apb(TCC_ADDR_TRIG, 1'b1, 32'h0);
    apb(TCC_ADDR_CTRL, 1'b1, 32'hF1);
    i_core.change_of_flow(17'h1_0F0F, 1'b0);
    @(posedge clk_sys);
    end_trace_reset <= 1'b1;
    @(posedge clk_sys);
    end_trace_reset <= 1'b0;
    rdc(TCC_ADDR_CTRL, 32'hA1);
    rdc(TCC_ADDR_EXT, 32'h01);
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    rdc(TCC_ADDR_EXT, 32'h0);
    secured <= 1'b1;
    apb(TCC_ADDR_CTRL, 1'b1, 32'hC0);
    rdc(TCC_ADDR_CTRL, 32'h40);
    chk({31'h0, armed_status_flag}, 32'h0);
    secured <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_capture();
    t_loop();
    t_break();
    t_ends();
    conclude();
  end
endmodule
